// >>> rtl/hlm_mult.sv
// Top of the nibble-table multiplier with reload sequencer and adder tree
// Functional notes
// (RQ1) Variable operand split into nibbles, one partial product each.
// (RQ2) Each 8x8 nibble partial product is twelve bits from its table.
// (RQ3) Low nibble product zero-extended to sixteen bits, weight one.
// (RQ4) High nibble product shifted left four places, weight sixteen.
// (RQ5) Sixteen-bit adder sums aligned partial products into the product.
// (RQ6) No overflow handling; n by m bits fits in n plus m.
// (RQ7) Tables have sixteen entries addressed only by the nibble.
// (RQ8) Entry k holds k times the coefficient.
// (RQ9) New coefficient rewrites all sixteen entries before use.
// (RQ10) Accumulator, address counter and state machine perform reload.
// (RQ11) All nibble tables receive identical contents.
// (RQ12) Products invalid during reload; user waits for completion.
// (RQ13) Variable operand change gives product after table and adder delay.
// (RQ14) Fixed coefficient uses preset tables without reload logic.
// (RQ15) Width extends by nibbles, extra tables and adder levels.
// (RQ16) Pipelined build registers table outputs and each adder.
// (RQ17) Signed operands via invert-and-add-one stages, signs separate.
// (RQ18) 16x16 variant has four tables of twenty-bit partial products.
// (RQ19) Two twenty-four-bit adders form low and high byte products.
// (RQ20) Thirty-two-bit adder sums bytes, high byte shifted by eight.
// (RQ21) Accumulator starts at zero, adds coefficient per address step.
// (RQ22) Busy from coefficient acceptance until last entry written.
`timescale 1ns/1ps
module hlm_mult
  import hlm_pkg::*;
#(
  parameter int          VAR_W     = HLM_VAR_W,
  parameter int          COEF_W    = HLM_COEF_W,
  parameter bit          FIXED     = 1'b0,
  parameter logic [15:0] FIXED_VAL = 16'h0000,
  parameter bit          PIPE      = 1'b0,
  parameter bit          SIGNED_OP = 1'b0
) (
  input  wire logic                     core_clk,
  input  wire logic                     reset,
  input  wire logic                     coef_load,
  input  wire logic [COEF_W-1:0]        coef_in,
  input  wire logic [VAR_W-1:0]         var_in,
  output logic      [VAR_W+COEF_W-1:0]  product,
  output logic                          busy
);
  localparam int NNIB  = VAR_W / HLM_NIB_W;  // [RQ15]
  localparam int PP_W  = COEF_W + HLM_NIB_W;
  localparam int RES_W = VAR_W + COEF_W;

  // Sign handling: magnitudes in, sign applied at the output  [RQ17]
  logic              coef_sign_q;
  logic [COEF_W-1:0] coef_mag;
  logic [VAR_W-1:0]  var_mag;
  logic              var_sign;
  logic              res_sign;

  always_comb begin
    coef_mag = coef_in;
    var_mag  = var_in;
    var_sign = 1'b0;
    if (SIGNED_OP) begin
      var_sign = var_in[VAR_W-1];
      if (coef_in[COEF_W-1]) coef_mag = COEF_W'(~coef_in + 1'b1);  // [RQ17]
      if (var_sign) var_mag = VAR_W'(~var_in + 1'b1);  // [RQ17]
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      coef_sign_q <= 1'b0;
    end else if (coef_load && !FIXED) begin
      // Fixed build ignores loads; its preset is a magnitude
      coef_sign_q <= SIGNED_OP ? coef_in[COEF_W-1] : 1'b0;
    end
  end

  logic            wr_en;
  logic [3:0]      wr_addr;
  logic [PP_W-1:0] wr_data;
  logic            rl_busy;

  generate
    if (FIXED) begin : g_noreload
      assign wr_en   = 1'b0;  // [RQ14]
      assign wr_addr = HLM_ADDR_FIRST;
      assign wr_data = '0;
      assign rl_busy = HLM_BUSY_RST;
    end else begin : g_reload
      hlm_reloader #(
        .COEF_W (COEF_W),
        .PP_W   (PP_W)
      ) u_reload (
        .core_clk  (core_clk),
        .reset     (reset),
        .coef_load (coef_load),
        .coef_in   (coef_mag),
        .wr_en     (wr_en),
        .wr_addr   (wr_addr),
        .wr_data   (wr_data),
        .busy      (rl_busy)
      );
    end
  endgenerate

  assign busy = rl_busy;  // [RQ22] [RQ12]

  // One table per nibble, all fed by the same write port  [RQ11] [RQ1]
  logic [PP_W-1:0] pp [NNIB];

  genvar gi;
  generate
    for (gi = 0; gi < NNIB; gi++) begin : g_tbl
      hlm_nib_table #(
        .PP_W      (PP_W),
        .FIXED     (FIXED),
        .FIXED_VAL (FIXED_VAL),
        .PIPE      (PIPE)
      ) u_tbl (
        .core_clk (core_clk),
        .reset    (reset),
        .wr_en    (wr_en),
        .wr_addr  (wr_addr),
        .wr_data  (wr_data),
        .nibble   (var_mag[gi*HLM_NIB_W +: HLM_NIB_W]),  // [RQ1] [RQ7]
        .pp       (pp[gi])
      );
    end
  endgenerate

  // Adder tree. Pairs of nibbles form byte products (weights 1 and 16),
  // then a final level weights bytes by 256. Widths always hold the
  // full product, so carries never spill.  [RQ6]
  localparam int NBYTE = (NNIB + 1) / 2;
  localparam int BP_W  = PP_W + HLM_NIB_W;
  logic [BP_W-1:0]  byte_d [NBYTE];
  logic [BP_W-1:0]  byte_q [NBYTE];
  logic [BP_W-1:0]  byte_s [NBYTE];
  logic [RES_W-1:0] sum_d;
  logic [RES_W-1:0] sum_q;
  logic [RES_W-1:0] sum_s;

  always_comb begin
    for (int b = 0; b < NBYTE; b++) begin
      byte_d[b] = BP_W'(pp[2*b]);  // [RQ3]
      if (2*b + 1 < NNIB) begin
        byte_d[b] = BP_W'(byte_d[b] + {pp[2*b+1], 4'h0});  // [RQ4] [RQ5] [RQ19]
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int b = 0; b < NBYTE; b++) byte_q[b] <= '0;
    end else begin
      for (int b = 0; b < NBYTE; b++) byte_q[b] <= byte_d[b];  // [RQ16]
    end
  end

  always_comb begin
    for (int b = 0; b < NBYTE; b++) begin
      byte_s[b] = PIPE ? byte_q[b] : byte_d[b];
    end
  end

  always_comb begin
    sum_d = '0;
    for (int b = 0; b < NBYTE; b++) begin
      sum_d = RES_W'(sum_d + (RES_W'(byte_s[b]) << (b*HLM_BYTE_SHIFT)));  // [RQ20]
    end
  end

  // Extra stage only when there is a byte level to add
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sum_q <= '0;
    end else begin
      sum_q <= sum_d;  // [RQ16]
    end
  end

  assign sum_s = (PIPE && NBYTE > 1) ? sum_q : sum_d;

  // Sign path delayed to match the data latency
  logic [2:0] sgn_q;
  logic       sgn_now;
  assign sgn_now = SIGNED_OP ? (var_sign ^ coef_sign_q) : 1'b0;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sgn_q <= '0;
    end else begin
      sgn_q <= {sgn_q[1:0], sgn_now};
    end
  end

  always_comb begin
    if (!PIPE) res_sign = sgn_now;
    else if (NBYTE > 1) res_sign = sgn_q[2];
    else res_sign = sgn_q[1];
  end

  // Combinational path when unpipelined: no reload on operand change  [RQ13]
  always_comb begin
    product = sum_s;
    if (res_sign) product = RES_W'(~sum_s + 1'b1);  // [RQ17]
  end
endmodule : hlm_mult

// >>> rtl/hlm_nib_table.sv
// One sixteen-entry partial-product table addressed by one nibble
`timescale 1ns/1ps
module hlm_nib_table
  import hlm_pkg::*;
#(
  parameter int          PP_W      = 12,
  parameter bit          FIXED     = 1'b0,
  parameter logic [15:0] FIXED_VAL = 16'h0000,
  parameter bit          PIPE      = 1'b0
) (
  input  wire logic            core_clk,
  input  wire logic            reset,
  input  wire logic            wr_en,
  input  wire logic [3:0]      wr_addr,
  input  wire logic [PP_W-1:0] wr_data,
  input  wire logic [3:0]      nibble,
  output logic      [PP_W-1:0] pp
);
  logic [PP_W-1:0] rd;
  logic [PP_W-1:0] pp_q;

  generate
    if (FIXED) begin : g_rom
      // Preset multiples, no write port or address mux  [RQ14]
      always_comb begin
        rd = PP_W'(PP_W'(nibble) * PP_W'(FIXED_VAL));  // [RQ8]
      end
    end else begin : g_ram
      logic [PP_W-1:0] mem_q [HLM_TBL_DEPTH];

      always_ff @(posedge core_clk) begin
        if (wr_en) begin
          mem_q[wr_addr] <= wr_data;
        end
      end
      // Only the nibble addresses the read side  [RQ7]
      always_comb begin
        rd = mem_q[nibble];
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pp_q <= '0;
    end else begin
      pp_q <= rd;  // [RQ16]
    end
  end

  assign pp = PIPE ? pp_q : rd;  // [RQ2] [RQ18]
endmodule : hlm_nib_table

// >>> rtl/hlm_pkg.sv
// Package with widths, reload timing and reload states for the table multiplier
package hlm_pkg;
  localparam int HLM_NIB_W      = 4;
  localparam int HLM_TBL_DEPTH  = 16;
  localparam int HLM_COEF_W     = 8;
  localparam int HLM_VAR_W      = 8;
  localparam int HLM_BYTE_SHIFT = 8;
  localparam int HLM_RELOAD_CYC = HLM_TBL_DEPTH;
  localparam logic [3:0] HLM_ADDR_FIRST = 4'h0;
  localparam logic [3:0] HLM_ADDR_LAST  = 4'hF;
  localparam logic       HLM_BUSY_RST   = 1'b0;

  typedef enum logic {
    HLM_ST_IDLE,
    HLM_ST_LOAD
  } hlm_state_e;
endpackage : hlm_pkg

// >>> rtl/hlm_reloader.sv
// Reload sequencer: accumulator, address counter and two-state machine
`timescale 1ns/1ps
module hlm_reloader
  import hlm_pkg::*;
#(
  parameter int COEF_W = HLM_COEF_W,
  parameter int PP_W   = 12
) (
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              coef_load,
  input  wire logic [COEF_W-1:0] coef_in,
  output logic                   wr_en,
  output logic      [3:0]        wr_addr,
  output logic      [PP_W-1:0]   wr_data,
  output logic                   busy
);
  hlm_state_e      state_q;
  logic [COEF_W-1:0] coef_q;
  logic [PP_W-1:0]   acc_q;
  logic [3:0]        addr_q;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q <= HLM_ST_IDLE;
    end else begin
      unique case (state_q)
        HLM_ST_IDLE: if (coef_load) state_q <= HLM_ST_LOAD;
        HLM_ST_LOAD: if (addr_q == HLM_ADDR_LAST && !coef_load) state_q <= HLM_ST_IDLE;
      endcase
    end
  end

  // A new coefficient mid-reload restarts the walk from entry zero  [RQ9]
  always_ff @(posedge core_clk) begin
    if (reset) begin
      coef_q <= '0;
      acc_q  <= '0;
      addr_q <= HLM_ADDR_FIRST;
    end else if (coef_load) begin
      coef_q <= coef_in;
      acc_q  <= '0;  // [RQ21]
      addr_q <= HLM_ADDR_FIRST;
    end else if (state_q == HLM_ST_LOAD) begin
      acc_q  <= PP_W'(acc_q + PP_W'(coef_q));  // [RQ21] [RQ10]
      addr_q <= addr_q + 4'h1;
    end
  end

  assign wr_en   = (state_q == HLM_ST_LOAD) && !coef_load;  // [RQ10]
  assign wr_addr = addr_q;
  assign wr_data = acc_q;
  assign busy    = (state_q == HLM_ST_LOAD) || coef_load;  // [RQ22] [RQ12]
endmodule : hlm_reloader

// >>> test/hlm_mult_monitor.sv
// Assertion checker on the table multiplier top ports
`timescale 1ns/1ps
module hlm_mult_monitor (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        coef_load,
  input wire logic [7:0]  coef_in,
  input wire logic [7:0]  var_in,
  input wire logic [15:0] product,
  input wire logic        busy
);
  logic [4:0] cnt_q;
  logic [7:0] coef_q;
  logic       ok;
  logic       quiet;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // Cycles since the last load; saturates once every entry is written
  always_ff @(posedge core_clk) begin
    if (reset) cnt_q <= 5'h00;
    else if (coef_load) cnt_q <= 5'h01;
    else if (cnt_q != 5'h00 && cnt_q != 5'h11) cnt_q <= cnt_q + 5'h01;
  end
  always_ff @(posedge core_clk) begin
    if (coef_load) coef_q <= coef_in;
  end
  // Products are judged only after a reload that ran to its end
  assign ok = (cnt_q == 5'h11) && !coef_load;
  assign quiet = (cnt_q == 5'h00) || (cnt_q == 5'h11);
  chk_busy_on_load: assert property (coef_load |-> busy)
    else $error("busy low during load");
  chk_busy_hold: assert property (!quiet |-> busy)
    else $error("busy dropped before last entry");
  chk_busy_idle: assert property ((!coef_load && quiet) |-> !busy)
    else $error("busy high outside reload");
  chk_busy_rise: assert property ($rose(busy) |-> coef_load)
    else $error("busy rose without load");
  chk_fall_count: assert property ($fell(busy) |-> cnt_q == 5'h11)
    else $error("reload length wrong");
  chk_product_ok: assert property (ok |-> product == ({8'h00, var_in} * {8'h00, coef_q}))
    else $error("product wrong");
  chk_low_pad: assert property ((ok && var_in[7:4] == 4'h0) |-> product[15:12] == 4'h0)
    else $error("low partial product not padded");
  chk_high_pad: assert property ((ok && var_in[3:0] == 4'h0) |-> product[3:0] == 4'h0)
    else $error("high partial product not shifted");
  cov_restart: cover property (coef_load && cnt_q != 5'h00 && cnt_q != 5'h11);
  cov_done: cover property ($fell(busy));
  cov_max: cover property (ok && product == 16'hFE01);
endmodule : hlm_mult_monitor

bind hlm_mult hlm_mult_monitor i_mon (.core_clk(core_clk), .reset(reset),
  .coef_load(coef_load), .coef_in(coef_in), .var_in(var_in), .product(product), .busy(busy));

// >>> test/hlm_mult_test.sv
// Self-checking bench for the table multiplier
`timescale 1ns/1ps
module hlm_mult_test;
  import hlm_pkg::*;
  logic        core_clk;
  logic        reset;
  logic        coef_load;
  logic [7:0]  coef_in;
  logic [7:0]  var_in;
  logic [15:0] product;
  logic        busy;
  logic        prod_ok;
  logic [7:0]  coef_cur;
  int          error_cnt;
  int          samples_checked;

  hlm_mult i_dut (.core_clk(core_clk), .reset(reset), .coef_load(coef_load),
    .coef_in(coef_in), .var_in(var_in), .product(product), .busy(busy));
  hlm_sys_model i_sys (.core_clk(core_clk), .coef_load(coef_load), .coef_in(coef_in),
    .busy(busy), .coef_q(coef_cur), .prod_ok(prod_ok));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  // Pulse a coefficient, then count busy cycles up to lim
  task automatic load(input logic [7:0] c, input int lim, output int n);
    @(negedge core_clk);
    coef_load = 1'b1;
    coef_in = c;
    #1 check({15'h0000, busy}, 16'h0001);
    @(negedge core_clk);
    coef_load = 1'b0;
    n = 1;
    while (busy === 1'b1 && n < lim) begin
      n++;
      @(negedge core_clk);
    end
  endtask : load

  task automatic mul(input logic [7:0] v);
    @(negedge core_clk);
    var_in = v;
    #1 check({15'h0000, prod_ok}, 16'h0001);
    check(product, {8'h00, v} * {8'h00, coef_cur});
  endtask : mul

  task automatic t_full();
    int n;
    load(8'hFF, 40, n);
    check(16'(n), 16'(HLM_RELOAD_CYC + 1));
    mul(8'hFF);
    check(product, 16'hFE01);
    mul(8'h0F);
    mul(8'hF0);
    mul(8'h00);
  endtask : t_full

  // Every entry through each nibble, changed on back-to-back cycles
  task automatic t_table();
    int n;
    load(8'h0D, 40, n);
    check(16'(n), 16'(HLM_RELOAD_CYC + 1));
    for (int k = 0; k < 16; k++) begin
      mul(8'(k));
      mul(8'(k << 4));
    end
  endtask : t_table

  // Second load in mid-reload restarts the walk from entry zero
  task automatic t_restart();
    int n;
    load(8'h37, 6, n);
    check(16'(n), 16'h0006);
    load(8'hA5, 40, n);
    check(16'(n), 16'(HLM_RELOAD_CYC + 1));
    mul(8'hC3);
    mul(8'h3C);
  endtask : t_restart

  initial begin
    error_cnt = 0;
    samples_checked = 0;
    reset = 1'b1;
    coef_load = 1'b0;
    coef_in = 8'h00;
    var_in = 8'h00;
    repeat (20) @(negedge core_clk);
    check({15'h0000, busy}, {15'h0000, HLM_BUSY_RST});
    reset = 1'b0;
    t_full();
    t_table();
    t_restart();
    end_of_test();
  end
endmodule : hlm_mult_test

// >>> test/hlm_sys_model.sv
// Model of the system logic that holds the loaded coefficient and says when products may be taken
`timescale 1ns/1ps
module hlm_sys_model (
  input  wire logic       core_clk,
  input  wire logic       coef_load,
  input  wire logic [7:0] coef_in,
  input  wire logic       busy,
  output logic      [7:0] coef_q,
  output logic            prod_ok
);
  always_ff @(posedge core_clk) begin
    if (coef_load) coef_q <= coef_in;
  end
  // Products are not trusted while tables are rewritten
  assign prod_ok = !busy;
endmodule : hlm_sys_model
